// *** hdl/bdm_data_memory.sv ***
// Banked data memory with pointer based indirect access
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Every data memory location holds one eight bit byte.
// - Two banks each hold general purpose bytes 80H to FFH.
// - Special locations shared by banks; control at 40H only in bank 1.
// - Address space starts at 00H with special registers lowest.
// - Unused special locations read as zero.
// - General purpose bytes are readable and writable.
// - Indirect ports redirect to the address held in their pointer.
// - Port zero reaches bank 0 only; port one follows bank select.
// - A pointer naming an indirect port reads 00H and writes nothing.
// - Both pointers are real readable and writable registers.
// - Direct addressing always reaches bank 0.
// - Bank pointer bit 0 selects the bank.
// - Bank pointer bits 7 to 1 read as zero.
// - Reset clears bank select except watchdog reset in power down.
// - No register to register move; data passes the working register.
module bdm_data_memory
	import bdm_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire bdm_req_t coreReq,
	input wire logic workLoad,
	input wire logic [7:0] workData,
	input wire logic wdtPdReset,
	output logic [7:0] coreRdata,
	output logic rdValid,
	output logic [7:0] workReg,
	output logic bankSel,
	output logic periphRd,
	output logic periphWr,
	output logic [7:0] periphAddr,
	output logic [7:0] periphWdata,
	input wire logic [7:0] periphRdata,
	output logic nvmCtrlRd,
	output logic nvmCtrlWr,
	output logic [7:0] nvmCtrlWdata,
	input wire logic [7:0] nvmCtrlRdata
);
	logic [7:0] ptrZero_reg, ptrZero_next;
	logic [7:0] ptrOne_reg, ptrOne_next;
	logic bank_reg, bank_next;
	logic [7:0] work_reg, work_next;
	logic [7:0] rdLocal_reg, rdLocal_next;
	logic [7:0] rdPeriph_reg, rdPeriph_next;
	bdm_tgt_t tgt_reg, tgt_next;
	logic rdValid_reg, rdValid_next;
	logic [7:0] effAddr;
	logic effBank;
	logic viaPort;
	logic [8:0] physAddr;
	bdm_tgt_t tgt;
	logic [7:0] gpRdata;
	logic gpWr;
	logic nvmHit;

	// Classify a local address; shared area below 80H except bank one control
	function automatic bdm_tgt_t decode(input logic [7:0] a, input logic bk, input logic ind);
		if (a >= BDM_GP_BASE) begin
			decode = BDM_TGT_GP;
		end else if (a == BDM_OFF_PORT0 || a == BDM_OFF_PORT1) begin
			decode = ind ? BDM_TGT_NONE : BDM_TGT_LOCAL;
		end else if (a <= BDM_OFF_WORK) begin
			decode = BDM_TGT_LOCAL;
		end else if (a == BDM_OFF_NVMC && bk) begin
			decode = BDM_TGT_LOCAL;
		end else if (a >= BDM_SFR_LIMIT) begin
			// Unused shared locations answer locally: read zero, ignore writes
			decode = BDM_TGT_LOCAL;
		end else begin
			decode = BDM_TGT_PERIPH;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Address resolution
	always_comb begin
		viaPort = 1'b0;
		effAddr = coreReq.addr;
		effBank = 1'b0;
		if (coreReq.addr == BDM_OFF_PORT0) begin
			viaPort = 1'b1;
			effAddr = ptrZero_reg;
			effBank = 1'b0;
		end else if (coreReq.addr == BDM_OFF_PORT1) begin
			viaPort = 1'b1;
			effAddr = ptrOne_reg;
			effBank = bank_reg;
		end
		physAddr = {effBank, effAddr};
		tgt = decode(effAddr, effBank, viaPort);
	end

	assign gpWr = coreReq.wr && tgt == BDM_TGT_GP;

	// The control register only answers in bank 1; in bank 0 40H is a shared register
	assign nvmHit = clkEn && tgt == BDM_TGT_LOCAL && effAddr == BDM_OFF_NVMC;

	// Peripheral pass through; strobes are gated so a frozen block changes nothing outside
	always_comb begin
		periphRd = clkEn && coreReq.rd && tgt == BDM_TGT_PERIPH;
		periphWr = clkEn && coreReq.wr && tgt == BDM_TGT_PERIPH;
		periphAddr = effAddr;
		periphWdata = coreReq.wdata;
		nvmCtrlRd = coreReq.rd && nvmHit;
		nvmCtrlWr = coreReq.wr && nvmHit;
		nvmCtrlWdata = coreReq.wdata;
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state of pointers, bank, working register and read capture
	always_comb begin
		ptrZero_next = ptrZero_reg;
		ptrOne_next = ptrOne_reg;
		bank_next = bank_reg;
		work_next = work_reg;
		rdLocal_next = BDM_ZERO;
		rdPeriph_next = rdPeriph_reg;
		tgt_next = tgt;
		rdValid_next = coreReq.rd;
		if (coreReq.wr && tgt == BDM_TGT_LOCAL) begin
			unique case (effAddr)
				BDM_OFF_PTR0: ptrZero_next = coreReq.wdata;
				BDM_OFF_PTR1: ptrOne_next = coreReq.wdata;
				BDM_OFF_BANK: bank_next = coreReq.wdata[BDM_BANK_BIT];
				BDM_OFF_WORK: work_next = coreReq.wdata;
				default: ;
			endcase
		end
		// The only load path from results into storage is the working register
		if (workLoad) begin
			work_next = workData;
		end
		if (coreReq.rd && tgt == BDM_TGT_LOCAL) begin
			unique case (effAddr)
				BDM_OFF_PTR0: rdLocal_next = ptrZero_reg;
				BDM_OFF_PTR1: rdLocal_next = ptrOne_reg;
				BDM_OFF_BANK: rdLocal_next = {7'h00, bank_reg};
				BDM_OFF_WORK: rdLocal_next = work_reg;
				BDM_OFF_NVMC: rdLocal_next = nvmCtrlRdata;
				default: rdLocal_next = BDM_ZERO;
			endcase
		end
		if (coreReq.rd && tgt == BDM_TGT_PERIPH) begin
			rdPeriph_next = periphRdata;
		end
	end

	// Registers of pointers, working register and read capture
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ptrZero_reg <= BDM_PTR_RST;
			ptrOne_reg <= BDM_PTR_RST;
			work_reg <= BDM_ZERO;
			rdLocal_reg <= BDM_ZERO;
			rdPeriph_reg <= BDM_ZERO;
			tgt_reg <= BDM_TGT_NONE;
			rdValid_reg <= 1'b0;
		end else if (clkEn) begin
			ptrZero_reg <= ptrZero_next;
			ptrOne_reg <= ptrOne_next;
			work_reg <= work_next;
			rdLocal_reg <= rdLocal_next;
			rdPeriph_reg <= rdPeriph_next;
			tgt_reg <= tgt_next;
			rdValid_reg <= rdValid_next;
		end
	end

	// Bank select has its own reset, masked while the reset is a power down watchdog one
	logic bankRst;
	assign bankRst = sys_rst & ~wdtPdReset;

	// Bank register; it takes no write for as long as any reset is applied
	always_ff @(posedge clk or posedge bankRst) begin
		if (bankRst) begin
			bank_reg <= BDM_BANK_RST;
		end else if (clkEn && !sys_rst) begin
			bank_reg <= bank_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// General purpose storage, 256 bytes over both banks
	bdm_gp_ram #(
		.WORDS(BDM_GP_WORDS),
		.AW(BDM_AW),
		.DW(BDM_DW)
	) u_ram (
		.clk(clk),
		.clkEn(clkEn),
		.wrEn(gpWr),
		.wrAddr({physAddr[8], physAddr[6:0]}),
		.wrData(coreReq.wdata),
		.rdAddr({physAddr[8], physAddr[6:0]}),
		.rdData(gpRdata)
	);

	// Read data one cycle after the request
	always_comb begin
		unique case (tgt_reg)
			BDM_TGT_GP: coreRdata = gpRdata;
			BDM_TGT_PERIPH: coreRdata = rdPeriph_reg;
			BDM_TGT_LOCAL: coreRdata = rdLocal_reg;
			BDM_TGT_NONE: coreRdata = BDM_ZERO;
		endcase
	end

	assign rdValid = rdValid_reg;
	assign workReg = work_reg;
	assign bankSel = bank_reg;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_port_zero_bank: assert property (@(posedge clk) disable iff (sys_rst)
		coreReq.addr == BDM_OFF_PORT0 |-> !physAddr[8])
		else $error("port zero left bank 0");
	a_direct_bank0: assert property (@(posedge clk) disable iff (sys_rst)
		!viaPort |-> !physAddr[8])
		else $error("direct access reached bank 1");
	a_port_one_addr: assert property (@(posedge clk) disable iff (sys_rst)
		coreReq.addr == BDM_OFF_PORT1 |-> physAddr == {bank_reg, ptrOne_reg})
		else $error("port one address wrong");
	a_bank_write: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && coreReq.wr && coreReq.addr == BDM_OFF_BANK |=> bank_reg == $past(coreReq.wdata[0]))
		else $error("bank bit not written");
	a_bank_upper_zero: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && coreReq.rd && coreReq.addr == BDM_OFF_BANK |=> coreRdata[7:1] == 7'h00)
		else $error("bank upper bits not zero");
	a_self_point_rd: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && coreReq.rd && viaPort && effAddr <= BDM_OFF_PORT1 && effAddr != BDM_OFF_PTR0
		|=> coreRdata == BDM_ZERO)
		else $error("indirect self read not zero");
	a_unused_zero: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && coreReq.rd && tgt == BDM_TGT_LOCAL && effAddr > BDM_OFF_WORK
		&& effAddr != BDM_OFF_NVMC |=> coreRdata == BDM_ZERO)
		else $error("unused location not zero");
	a_nvm_bank_one: assert property (@(posedge clk) disable iff (sys_rst)
		nvmCtrlRd || nvmCtrlWr |-> physAddr == {1'b1, BDM_OFF_NVMC})
		else $error("control reached outside bank 1");
	a_ptr_write: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && coreReq.wr && coreReq.addr == BDM_OFF_PTR1 |=> ptrOne_reg == $past(coreReq.wdata))
		else $error("pointer one not written");
	a_port_no_store: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && coreReq.wr && coreReq.addr == BDM_OFF_PORT1 && ptrOne_reg == BDM_OFF_PTR0
		|=> ptrZero_reg == $past(coreReq.wdata))
		else $error("indirect write not redirected");
	a_work_load: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && workLoad |=> workReg == $past(workData))
		else $error("working register not loaded");

	// Bank bit across the two kinds of reset
	a_reset_bank: assert property (@(posedge clk)
		sys_rst && !wdtPdReset |-> bankSel == BDM_BANK_RST)
		else $error("bank select not cleared by reset");
	a_wdt_keep_bank: assert property (@(posedge clk)
		sys_rst && wdtPdReset |=> bankSel == $past(bankSel))
		else $error("bank select lost in power down watchdog reset");

	// Shared area decoding and the bank one control register
	a_periph_strobe: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && coreReq.rd && !viaPort && coreReq.addr > BDM_OFF_WORK
		&& coreReq.addr < BDM_SFR_LIMIT |-> periphRd && periphAddr == coreReq.addr)
		else $error("shared register read not passed on");
	a_nvm_decode: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && coreReq.rd && coreReq.addr == BDM_OFF_PORT1 && ptrOne_reg == BDM_OFF_NVMC
		&& bank_reg |-> nvmCtrlRd && !periphRd)
		else $error("control register not reached in bank 1");
	a_nvm_hidden: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && coreReq.rd && coreReq.addr == BDM_OFF_PORT1 && ptrOne_reg == BDM_OFF_NVMC
		&& !bank_reg |-> periphRd && !nvmCtrlRd)
		else $error("control register reached in bank 0");
	a_unused_no_write: assert property (@(posedge clk) disable iff (sys_rst)
		coreReq.wr && !viaPort && coreReq.addr >= BDM_SFR_LIMIT
		&& coreReq.addr < BDM_GP_BASE |-> !periphWr && !gpWr && !nvmCtrlWr)
		else $error("unused location accepted a write");

	// General purpose storage and read handshake
	a_gp_write: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && coreReq.wr && !viaPort && coreReq.addr >= BDM_GP_BASE |-> gpWr)
		else $error("general purpose write dropped");
	a_rd_valid: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && coreReq.rd |=> rdValid)
		else $error("read not answered");
	a_port_zero_write: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && coreReq.wr && coreReq.addr == BDM_OFF_PORT0
		&& ptrZero_reg >= BDM_GP_BASE |-> gpWr && !physAddr[8])
		else $error("port zero write not in bank 0");

	// Pointers, self pointing ports and the bank register read back
	a_self_point_wr: assert property (@(posedge clk) disable iff (sys_rst)
		coreReq.wr && viaPort && (effAddr == BDM_OFF_PORT0 || effAddr == BDM_OFF_PORT1)
		|-> !gpWr && !periphWr && !nvmCtrlWr)
		else $error("indirect self write did something");
	a_ptr0_write: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && coreReq.wr && coreReq.addr == BDM_OFF_PTR0
		|=> ptrZero_reg == $past(coreReq.wdata))
		else $error("pointer zero not written");
	a_bank_rd_value: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && coreReq.rd && coreReq.addr == BDM_OFF_BANK |=> coreRdata[0] == $past(bank_reg))
		else $error("bank bit read back wrong");
endmodule
`default_nettype wire

// *** hdl/bdm_gp_ram.sv ***
// General purpose storage for both banks, registered read data
`timescale 1ns/100ps
`default_nettype none
module bdm_gp_ram #(
	parameter int WORDS = 256,
	parameter int AW = 8,
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic clkEn,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [DW-1:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [DW-1:0] rdData
);
	logic [DW-1:0] mem [WORDS];

	// Write port and registered read port
	always_ff @(posedge clk) begin
		if (clkEn) begin
			if (wrEn) begin
				mem[wrAddr] <= wrData;
			end
			rdData <= mem[rdAddr];
		end
	end
endmodule
`default_nettype wire

// *** hdl/bdm_pkg.sv ***
// Package of constants and types for the banked data memory block
package bdm_pkg;
	localparam int BDM_DW = 8;
	localparam int BDM_AW = 8;
	localparam logic [7:0] BDM_OFF_PORT0 = 8'h00;
	localparam logic [7:0] BDM_OFF_PTR0 = 8'h01;
	localparam logic [7:0] BDM_OFF_PORT1 = 8'h02;
	localparam logic [7:0] BDM_OFF_PTR1 = 8'h03;
	localparam logic [7:0] BDM_OFF_BANK = 8'h04;
	localparam logic [7:0] BDM_OFF_WORK = 8'h05;
	localparam logic [7:0] BDM_OFF_NVMC = 8'h40;
	localparam logic [7:0] BDM_GP_BASE = 8'h80;
	localparam logic [7:0] BDM_SFR_LIMIT = 8'h53;
	localparam int BDM_BANK_BIT = 0;
	localparam logic [7:0] BDM_ZERO = 8'h00;
	localparam logic BDM_BANK_RST = 1'b0;
	localparam logic [7:0] BDM_PTR_RST = 8'h00;
	localparam int BDM_GP_WORDS = 256;

	// One access request from the core
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bdm_req_t;

	// Where a resolved address lands
	typedef enum logic [1:0] {BDM_TGT_NONE, BDM_TGT_LOCAL, BDM_TGT_PERIPH, BDM_TGT_GP} bdm_tgt_t;
endpackage

// *** verification/bdm_periph_model.sv ***
// Model of the peripheral registers and the control register behind the block
`timescale 1ns/100ps
`default_nettype none
module bdm_periph_model (
	input wire logic clk,
	input wire logic periphRd,
	input wire logic periphWr,
	input wire logic [7:0] periphAddr,
	input wire logic [7:0] periphWdata,
	output logic [7:0] periphRdata,
	input wire logic nvmCtrlRd,
	input wire logic nvmCtrlWr,
	input wire logic [7:0] nvmCtrlWdata,
	output logic [7:0] nvmCtrlRdata
);
	logic [7:0] regs [0:127];
	logic [7:0] nvmReg;
	logic [7:0] pVal;
	logic [7:0] pLast = 8'h00;
	logic [7:0] nLast = 8'h00;
	initial nvmReg = 8'h00;
	initial for (int i = 0; i < 128; i++) regs[i] = 8'h00;
	// Unused shared locations read as zero
	assign pVal = (periphAddr < 8'h53) ? regs[periphAddr[6:0]] : 8'h00;
	// Idle read lines show the inverse of the last value
	assign periphRdata = periphRd ? pVal : ~pLast;
	assign nvmCtrlRdata = nvmCtrlRd ? nvmReg : ~nLast;
	// Register writes and remember the last returned values
	always @(posedge clk) begin
		if (periphWr) regs[periphAddr[6:0]] <= periphWdata;
		if (nvmCtrlWr) nvmReg <= nvmCtrlWdata;
		if (periphRd) pLast <= pVal;
		if (nvmCtrlRd) nLast <= nvmReg;
	end
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking testbench for the banked data memory
`timescale 1ns/100ps
`default_nettype none
module tb;
	import bdm_pkg::*;
	logic clk, sysRst, workLoad, rdValid, bankSel, periphRd, periphWr, nvmCtrlRd, nvmCtrlWr;
	logic clkEn, wdtPdReset;
	logic [7:0] workData, coreRdata, workReg, periphAddr, periphWdata, periphRdata;
	logic [7:0] nvmCtrlWdata, nvmCtrlRdata;
	bdm_req_t coreReq;
	int numErrors = 0;
	int samplesChecked = 0;
	bdm_data_memory i_bdm_data_memory (.clk(clk), .sys_rst(sysRst), .clkEn(clkEn),
		.coreReq(coreReq), .workLoad(workLoad), .workData(workData), .wdtPdReset(wdtPdReset),
		.coreRdata(coreRdata), .rdValid(rdValid), .workReg(workReg), .bankSel(bankSel),
		.periphRd(periphRd), .periphWr(periphWr), .periphAddr(periphAddr),
		.periphWdata(periphWdata), .periphRdata(periphRdata), .nvmCtrlRd(nvmCtrlRd),
		.nvmCtrlWr(nvmCtrlWr), .nvmCtrlWdata(nvmCtrlWdata), .nvmCtrlRdata(nvmCtrlRdata));
	bdm_periph_model i_bdm_periph_model (.clk(clk), .periphRd(periphRd),
		.periphWr(periphWr), .periphAddr(periphAddr), .periphWdata(periphWdata),
		.periphRdata(periphRdata), .nvmCtrlRd(nvmCtrlRd), .nvmCtrlWr(nvmCtrlWr),
		.nvmCtrlWdata(nvmCtrlWdata), .nvmCtrlRdata(nvmCtrlRdata));
	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			numErrors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One request, held across one rising edge; the next call or idle replaces it
	task automatic acc(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
		coreReq = '{rd: r, wr: w, addr: a, wdata: d};
		@(posedge clk);
		#1;
	endtask
	// Drop the request and let one edge pass
	task automatic idle();
		coreReq = '0;
		@(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(1'b0, 1'b1, a, d);
	endtask
	// Read and compare, answer one cycle later
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		acc(1'b1, 1'b0, a, 8'h00);
		chk({7'h00, rdValid}, 8'h01);
		chk(coreRdata, exp);
	endtask
	task automatic finish_test();
		if (numErrors == 0 && samplesChecked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		rdc(BDM_OFF_PTR0, 8'h00);
		rdc(BDM_OFF_BANK, 8'h00);
		rdc(BDM_OFF_WORK, 8'h00);
	endtask
	task automatic t_direct();
		wr(8'h80, 8'h3c);
		wr(8'hff, 8'hc3);
		rdc(8'h80, 8'h3c);
		rdc(8'hff, 8'hc3);
		wr(BDM_OFF_PTR1, 8'ha5);
		rdc(BDM_OFF_PTR1, 8'ha5);
		wr(8'h20, 8'h77);
		rdc(8'h20, 8'h77);
		rdc(8'h60, 8'h00);
	endtask
	task automatic t_bank();
		wr(BDM_OFF_BANK, 8'hff);
		rdc(BDM_OFF_BANK, 8'h01);
		idle();
		chk({7'h00, bankSel}, 8'h01);
		// Watchdog reset in power down keeps the bank, an ordinary reset clears it
		wdtPdReset = 1'b1;
		sysRst = 1'b1;
		@(posedge clk);
		#1;
		chk({7'h00, bankSel}, 8'h01);
		sysRst = 1'b0;
		wdtPdReset = 1'b0;
		@(posedge clk);
		#1;
		chk({7'h00, bankSel}, 8'h01);
		sysRst = 1'b1;
		#1;
		chk({7'h00, bankSel}, 8'h00);
		@(posedge clk);
		#1;
		sysRst = 1'b0;
	endtask
	task automatic t_banked();
		wr(8'h80, 8'h11);
		wr(BDM_OFF_BANK, 8'h01);
		wr(BDM_OFF_PTR1, 8'h80);
		wr(BDM_OFF_PORT1, 8'h22);
		rdc(BDM_OFF_PORT1, 8'h22);
		rdc(8'h80, 8'h11);
		wr(BDM_OFF_PTR0, 8'h80);
		rdc(BDM_OFF_PORT0, 8'h11);
		wr(BDM_OFF_BANK, 8'h00);
		rdc(BDM_OFF_PORT1, 8'h11);
		wr(BDM_OFF_PTR0, BDM_OFF_PORT1);
		wr(BDM_OFF_PORT0, 8'h55);
		rdc(BDM_OFF_PORT0, 8'h00);
		rdc(8'h80, 8'h11);
		wr(BDM_OFF_PTR1, BDM_OFF_PTR0);
		wr(BDM_OFF_PORT1, 8'h5a);
		rdc(BDM_OFF_PTR0, 8'h5a);
		idle();
	endtask
	task automatic t_nvm();
		wr(BDM_OFF_PTR1, 8'h40);
		wr(BDM_OFF_BANK, 8'h01);
		coreReq = '{rd: 1'b0, wr: 1'b1, addr: BDM_OFF_PORT1, wdata: 8'h09};
		#1;
		chk({7'h00, nvmCtrlWr}, 8'h01);
		chk(nvmCtrlWdata, 8'h09);
		@(posedge clk);
		#1;
		rdc(BDM_OFF_PORT1, 8'h09);
		wr(BDM_OFF_BANK, 8'h00);
		rdc(BDM_OFF_PORT1, 8'h00);
		rdc(BDM_OFF_NVMC, 8'h00);
		idle();
	endtask
	task automatic t_work();
		workData = 8'ha5;
		workLoad = 1'b1;
		@(posedge clk);
		#1;
		workLoad = 1'b0;
		chk(workReg, 8'ha5);
		rdc(BDM_OFF_WORK, 8'ha5);
		idle();
	endtask
	// Requests while the clock enable is low change nothing
	task automatic t_freeze();
		clkEn = 1'b0;
		wr(BDM_OFF_PTR0, 8'hc3);
		wr(8'h21, 8'hc3);
		clkEn = 1'b1;
		rdc(BDM_OFF_PTR0, 8'h5a);
		rdc(8'h21, 8'h00);
		idle();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Clock, watchdog and main sequence
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#20000;
		numErrors++;
		finish_test();
	end
	initial begin
		wdtPdReset = 1'b0;
		clkEn = 1'b1;
		sysRst = 1'b1;
		coreReq = '0;
		workLoad = 1'b0;
		workData = 8'h00;
		repeat (4) @(posedge clk);
		#1;
		sysRst = 1'b0;
		t_reset();
		t_direct();
		t_bank();
		t_banked();
		t_nvm();
		t_work();
		t_freeze();
		finish_test();
	end
endmodule
`default_nettype wire
